// >>> asmc_host.sv
`timescale 1ns/1ps
// Function
// RL1: When select is high the module floats its data lines and powers down.
// RL2: Select low, strobe high and output enable low makes the module drive read data.
// RL3: Select low and strobe low writes the bus into the module, which does not drive.
// RL4: Select low with strobe and output enable high keeps the module selected but floating.
// RL5: A write starts only while select and strobe are both low; their overlap is the write.
// RL6: A write ends when either select or strobe rises, whichever is first.
// RL7: The host holds write data stable around the edge that ends the write.
// RL8: For a read the host sets the address no later than select falling.
// RL9: The module floats its data lines while output enable is high, writes included.
// RL10: The module holds 128K bytes, so the address has seventeen bits with a top bit.
// RL11: The host releases its data drivers before enabling module outputs for a read.
module asmc_host
   import asmc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // User request
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [ASMC_AW-1:0] req_addr,
   input wire logic [ASMC_DW-1:0] req_wdata,
   output logic req_ready,
   output logic rsp_valid,
   output logic [ASMC_DW-1:0] rsp_rdata,
   // Module pins
   output logic mem_sel_n,
   output logic mem_we_n,
   output logic mem_oe_n,
   output logic [ASMC_AW-1:0] mem_addr,
   input wire logic [ASMC_DW-1:0] mem_dq_i,
   output logic [ASMC_DW-1:0] mem_dq_o,
   output logic mem_dq_oe_n
);
   asmc_state_t state_q;
   logic [7:0] cnt_q;
   logic [ASMC_DW-1:0] dq_s1_q;
   logic [ASMC_DW-1:0] dq_s2_q;

   // ----------------------------------------
   // Data input synchroniser
   // ----------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dq_s1_q <= ASMC_DATA_RST;
         dq_s2_q <= ASMC_DATA_RST;
      end else begin
         dq_s1_q <= mem_dq_i;
         dq_s2_q <= dq_s1_q;
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= ASMC_IDLE;
         cnt_q <= 8'h00;
         mem_sel_n <= 1'b1;
         mem_we_n <= 1'b1;
         mem_oe_n <= 1'b1;
         mem_addr <= ASMC_ADDR_RST;
         mem_dq_o <= ASMC_DATA_RST;
         mem_dq_oe_n <= 1'b1;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= ASMC_DATA_RST;
      end else begin
         rsp_valid <= 1'b0;
         case (state_q)
            ASMC_IDLE: begin
               req_ready <= 1'b1;
               if (req_valid && req_ready) begin
                  req_ready <= 1'b0;
                  mem_addr <= req_addr; // RL8 RL10
                  cnt_q <= 8'h00;
                  if (req_write) begin
                     mem_dq_o <= req_wdata;
                     mem_dq_oe_n <= 1'b0;
                     mem_sel_n <= 1'b0;
                     state_q <= ASMC_WR_SETUP;
                  end else begin
                     // Select falls with the address, outputs still off
                     mem_dq_oe_n <= 1'b1; // RL11
                     mem_sel_n <= 1'b0; // RL8
                     state_q <= ASMC_RD_SEL;
                  end
               end
            end
            ASMC_RD_SEL: begin
               mem_oe_n <= 1'b0; // RL2 RL11
               cnt_q <= 8'h00;
               state_q <= ASMC_RD_OE;
            end
            ASMC_RD_OE: begin
               cnt_q <= cnt_q + 8'h01;
               // Two extra cycles cover the input synchroniser
               if (cnt_q == 8'(ASMC_T_AA_CYC + 2)) begin
                  rsp_rdata <= dq_s2_q;
                  rsp_valid <= 1'b1;
                  mem_oe_n <= 1'b1;
                  mem_sel_n <= 1'b1; // RL1
                  cnt_q <= 8'h00;
                  state_q <= ASMC_TURN;
               end
            end
            ASMC_WR_SETUP: begin
               cnt_q <= cnt_q + 8'h01;
               if (cnt_q == 8'(ASMC_T_SA_CYC - 1)) begin
                  mem_we_n <= 1'b0; // RL5 RL3
                  cnt_q <= 8'h00;
                  state_q <= ASMC_WR_PULSE;
               end
            end
            ASMC_WR_PULSE: begin
               cnt_q <= cnt_q + 8'h01;
               if (cnt_q == 8'(ASMC_T_PWE_CYC - 1)) begin
                  // Strobe ends the write; select rises later
                  mem_we_n <= 1'b1; // RL6
                  cnt_q <= 8'h00;
                  state_q <= ASMC_WR_HOLD;
               end
            end
            ASMC_WR_HOLD: begin
               cnt_q <= cnt_q + 8'h01;
               if (cnt_q == 8'(ASMC_T_HD_CYC - 1)) begin
                  mem_dq_oe_n <= 1'b1; // RL7
                  mem_sel_n <= 1'b1;
                  state_q <= ASMC_IDLE;
               end
            end
            ASMC_TURN: begin
               // Let module drivers go high-Z before the next access
               cnt_q <= cnt_q + 8'h01;
               if (cnt_q == 8'(ASMC_T_HZOE_CYC - 1)) begin
                  state_q <= ASMC_IDLE; // RL11
               end
            end
            default: begin
               state_q <= ASMC_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_wr_start;
      !mem_sel_n && $fell(mem_we_n);
   endsequence
   property p_wr_overlap;
      @(posedge core_clk) disable iff (rst)
      !mem_we_n |-> !mem_sel_n;
   endproperty
   a_wr_overlap: assert property (p_wr_overlap) else $error("strobe low without select"); // RL5
   property p_wr_pulse;
      @(posedge core_clk) disable iff (rst)
      s_wr_start |-> !mem_we_n [*7] ##1 mem_we_n;
   endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse length wrong"); // RL6
   property p_wr_hold;
      @(posedge core_clk) disable iff (rst)
      $rose(mem_we_n) |-> $stable(mem_dq_o) && !mem_dq_oe_n && !mem_sel_n;
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write data not held"); // RL7
   property p_rd_no_fight;
      @(posedge core_clk) disable iff (rst)
      !mem_oe_n |-> mem_dq_oe_n && mem_we_n;
   endproperty
   a_rd_no_fight: assert property (p_rd_no_fight) else $error("bus driven during read"); // RL11
   property p_rd_addr;
      @(posedge core_clk) disable iff (rst)
      !mem_sel_n && mem_we_n |-> $stable(mem_addr) || $fell(mem_sel_n);
   endproperty
   a_rd_addr: assert property (p_rd_addr) else $error("address moved while selected"); // RL8
   property p_rd_len;
      @(posedge core_clk) disable iff (rst)
      $fell(mem_oe_n) |-> ##[1:20] rsp_valid;
   endproperty
   a_rd_len: assert property (p_rd_len) else $error("read did not complete"); // RL2
   // Select must already be settled when the strobe falls
   property p_wr_start;
      @(posedge core_clk) disable iff (rst)
      $fell(mem_we_n) |-> !$past(mem_sel_n) && !mem_dq_oe_n;
   endproperty
   a_wr_start: assert property (p_wr_start) else $error("strobe before select"); // RL5
   property p_wr_data;
      @(posedge core_clk) disable iff (rst)
      !mem_we_n |-> $stable(mem_dq_o) && !mem_dq_oe_n;
   endproperty
   a_wr_data: assert property (p_wr_data) else $error("write data moved"); // RL7
   sequence s_wr_end;
      $rose(mem_we_n) && !mem_sel_n;
   endsequence
   sequence s_wr_release;
      $rose(mem_sel_n) && mem_dq_oe_n && mem_we_n;
   endsequence
   property p_wr_end;
      @(posedge core_clk) disable iff (rst)
      s_wr_end |=> s_wr_release;
   endproperty
   a_wr_end: assert property (p_wr_end) else $error("select did not follow strobe"); // RL6
   property p_rd_turn;
      @(posedge core_clk) disable iff (rst)
      $rose(mem_oe_n) |-> mem_dq_oe_n [*3];
   endproperty
   a_rd_turn: assert property (p_rd_turn) else $error("bus driven in turnaround"); // RL11
   property p_rd_oe_sel;
      @(posedge core_clk) disable iff (rst)
      $fell(mem_oe_n) |-> !$past(mem_sel_n) && $stable(mem_addr);
   endproperty
   a_rd_oe_sel: assert property (p_rd_oe_sel) else $error("enable before select"); // RL8
   property p_desel_quiet;
      @(posedge core_clk) disable iff (rst)
      mem_sel_n |-> mem_we_n && mem_oe_n;
   endproperty
   a_desel_quiet: assert property (p_desel_quiet) else $error("pins active unselected"); // RL5
   property p_rd_done;
      @(posedge core_clk) disable iff (rst)
      rsp_valid |-> mem_sel_n && mem_oe_n;
   endproperty
   a_rd_done: assert property (p_rd_done) else $error("read answered while selected"); // RL2
endmodule

// >>> asmc_mem.sv
`timescale 1ns/1ps
module asmc_mem
   import asmc_pkg::*;
(
   // Module pins
   input wire logic sel_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic [ASMC_AW-1:0] addr,
   // Host side of the shared bus
   input wire logic [ASMC_DW-1:0] host_d,
   input wire logic host_oe_n,
   // Resolved bus level
   output logic [ASMC_DW-1:0] bus
);
   logic [ASMC_DW-1:0] mem [0:(1<<ASMC_AW)-1];
   logic [ASMC_DW-1:0] last;
   logic drv;
   logic wr;
   assign wr = !sel_n && !we_n;
   assign drv = !sel_n && we_n && !oe_n;
   // Data is taken at the edge that ends the overlap
   always @(negedge wr) if (!$isunknown(addr)) mem[addr] = host_d;
   // Released bus shows the inverse so stale data cannot pass
   always @* begin
      if (!host_oe_n && drv) bus = 'x;
      else if (!host_oe_n) bus = host_d;
      else if (drv) bus = mem[addr];
      else bus = ~last;
   end
   always @(bus) if (!host_oe_n || drv) last = bus;
endmodule

// >>> asmc_pkg.sv
package asmc_pkg;
   localparam int ASMC_AW = 17;
   localparam int ASMC_DW = 8;
   localparam int ASMC_CLK_PS = 8000;
   // Timing of the slowest 128K x 8 grade, in ns
   localparam int ASMC_T_AA_NS = 55;
   localparam int ASMC_T_SA_NS = 5;
   localparam int ASMC_T_PWE_NS = 55;
   localparam int ASMC_T_HD_NS = 5;
   localparam int ASMC_T_HZOE_NS = 20;
   localparam int ASMC_T_AA_CYC = (ASMC_T_AA_NS * 1000 + ASMC_CLK_PS - 1) / ASMC_CLK_PS;
   localparam int ASMC_T_SA_CYC = (ASMC_T_SA_NS * 1000 + ASMC_CLK_PS - 1) / ASMC_CLK_PS;
   localparam int ASMC_T_PWE_CYC = (ASMC_T_PWE_NS * 1000 + ASMC_CLK_PS - 1) / ASMC_CLK_PS;
   localparam int ASMC_T_HD_CYC = (ASMC_T_HD_NS * 1000 + ASMC_CLK_PS - 1) / ASMC_CLK_PS;
   localparam int ASMC_T_HZOE_CYC = (ASMC_T_HZOE_NS * 1000 + ASMC_CLK_PS - 1) / ASMC_CLK_PS;
   localparam logic [ASMC_AW-1:0] ASMC_ADDR_RST = 17'h00000;
   localparam logic [ASMC_DW-1:0] ASMC_DATA_RST = 8'h00;
   typedef enum logic [2:0] {
      ASMC_IDLE = 3'h0,
      ASMC_RD_SEL = 3'h1,
      ASMC_RD_OE = 3'h2,
      ASMC_WR_SETUP = 3'h3,
      ASMC_WR_PULSE = 3'h4,
      ASMC_WR_HOLD = 3'h5,
      ASMC_TURN = 3'h6
   } asmc_state_t;
endpackage

// >>> tb.sv
`timescale 1ns/1ps
module tb;
   import asmc_pkg::*;
   logic core_clk, rst, req_valid, req_write, req_ready, rsp_valid;
   logic mem_sel_n, mem_we_n, mem_oe_n, mem_dq_oe_n;
   logic [ASMC_AW-1:0] req_addr, mem_addr;
   logic [ASMC_DW-1:0] req_wdata, rsp_rdata, mem_dq_i, mem_dq_o;
   int bad_count = 0;
   int total_checks = 0;
   asmc_host u_asmc_host(.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .mem_sel_n(mem_sel_n), .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n),
      .mem_addr(mem_addr), .mem_dq_i(mem_dq_i), .mem_dq_o(mem_dq_o),
      .mem_dq_oe_n(mem_dq_oe_n));
   asmc_mem u_asmc_mem(.sel_n(mem_sel_n), .we_n(mem_we_n), .oe_n(mem_oe_n),
      .addr(mem_addr), .host_d(mem_dq_o), .host_oe_n(mem_dq_oe_n), .bus(mem_dq_i));
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [ASMC_AW-1:0] got, input logic [ASMC_AW-1:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One access; d is write data or expected read data
   task automatic op(input logic w, input logic [ASMC_AW-1:0] a, input logic [ASMC_DW-1:0] d);
      int n;
      int rk;
      int wl;
      n = 0;
      rk = 0;
      wl = 0;
      req_valid = 1'b1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      while (req_ready !== 1'b1 && n < 50) begin
         @(negedge core_clk);
         n++;
      end
      n = 0;
      @(negedge core_clk);
      req_valid = 1'b0;
      while (req_ready !== 1'b1 && n < 50) begin
         n++;
         if (rsp_valid === 1'b1) rk = n;
         if (mem_we_n === 1'b0) wl++;
         if (w) chk(mem_oe_n, 1'b1);
         else chk(mem_dq_oe_n, 1'b1);
         @(negedge core_clk);
      end
      chk(req_ready, 1'b1);
      chk(mem_sel_n, 1'b1);
      // Read answer: take, select, access, two sync stages, sample edge
      if (w) chk(17'(wl), 17'(ASMC_T_PWE_CYC));
      else chk(17'(rk), 17'(ASMC_T_AA_CYC + 5));
      if (!w) chk(rsp_rdata, d);
   endtask
   task automatic s_idle;
      chk({mem_sel_n, mem_we_n, mem_oe_n, mem_dq_oe_n}, 4'hf);
   endtask
   task automatic s_halves;
      op(1'b1, 17'h00005, 8'ha5);
      op(1'b1, 17'h10005, 8'h3c);
      op(1'b0, 17'h00005, 8'ha5);
      op(1'b0, 17'h10005, 8'h3c);
   endtask
   task automatic s_overwrite;
      op(1'b1, 17'h1ffff, 8'hff);
      op(1'b1, 17'h1ffff, 8'h00);
      op(1'b0, 17'h1ffff, 8'h00);
      s_idle();
   endtask
   initial begin
      rst = 1'b1;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 17'h00000;
      req_wdata = 8'h00;
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      repeat (2) @(negedge core_clk);
      s_idle();
      s_halves();
      s_overwrite();
      final_report();
   end
   // About 106 cycles are needed; allow a wide margin
   initial begin
      #20000;
      bad_count++;
      final_report();
   end
endmodule
